// ### core/pump_adc_ctrl.sv
// Top: pump and regulator control, bandgap quick start, slope converter control and comparator edge flag
// Behaviour
// - Pump clock = sysclk/16/(divider+1)
// - Control: divider 7..3, quickstart, pump, module
// - Pump enable ignored while module disabled
// - Module off powers down analog and converter
// - Module on: regulator on, pump per enable
// - Quick-start 0 shorts filter, 1 filters
// - Bandgap follows regulator enable
// - Converter power switches whole converter block
// - Chopper enable gates divided chopper clock
// - Comparator readable; trigger mode selects edges
// - Slope field drives integrator input switch
// - Input select field; gain bit 2 or 4
// - Reference select bit picks tap set
// - Comparator falls at one sixth during discharge
// - Trigger: none, rise, fall, both
// - Slope: 01 charge, 10 discharge, others reserved
// - Chopper = sysclk/32/2^sel
// - Input: sensor, thermal/battery, chopper pin
`timescale 1ns/10ps
`default_nettype none
module pump_adc_ctrl (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic comparator_out,
    output logic pump_clk,
    output logic chopper_clk,
    output pump_adc_pkg::analog_ctrl_t analog_ctrl,
    output logic conv_irq
);
    pump_adc_pkg::reg_req_t req;
    logic [7:0] pump_ctrl_reg;
    logic [7:0] conv_ctrl_reg;
    logic [7:0] conv_clk_reg;
    logic irq_flag_reg;
    logic cmp_meta_reg;
    logic cmp_sync_reg;
    logic cmp_prev_reg;
    logic pump_restart_reg;
    logic pump_clk_raw;
    logic chop_clk_raw;
    logic module_en;
    logic pump_run;
    logic conv_on;
    logic edge_hit;
    logic [6:0] chop_last;
    logic [7:0] chop_term;
    pump_adc_pkg::analog_ctrl_t analog_next;
    pump_adc_pkg::trig_mode_t trig;
    pump_adc_pkg::slope_t slope;

    function automatic logic [7:0] chop_terminal(input logic [2:0] sel);
        chop_terminal = (8'h01 << sel) - 8'h01;
    endfunction

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign module_en = pump_ctrl_reg[pump_adc_pkg::MODULE_EN_BIT];
    assign pump_run = module_en && pump_ctrl_reg[pump_adc_pkg::PUMP_EN_BIT];
    // Converter is unpowered whenever the regulator supply is down
    assign conv_on = module_en && conv_ctrl_reg[pump_adc_pkg::CONV_PWR_BIT];
    assign trig = pump_adc_pkg::trig_mode_t'(conv_ctrl_reg[pump_adc_pkg::TRIG_LSB +: 2]);
    assign slope = pump_adc_pkg::slope_t'(conv_ctrl_reg[pump_adc_pkg::SLOPE_LSB +: 2]);
    assign chop_term = chop_terminal(conv_clk_reg[pump_adc_pkg::CHOP_DIV_LSB +: 3]);
    // Largest terminal count is 127, so the top bit is always zero
    assign chop_last = chop_term[6:0];

    // Register writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pump_ctrl_reg <= pump_adc_pkg::PUMP_CTRL_RESET;
            conv_ctrl_reg <= pump_adc_pkg::CONV_CTRL_RESET;
            conv_clk_reg <= pump_adc_pkg::CONV_CLK_RESET;
        end else if (req.wr) begin
            case (req.addr)
                pump_adc_pkg::ADDR_PUMP_CTRL: begin
                    pump_ctrl_reg <= req.wdata;
                end
                pump_adc_pkg::ADDR_CONV_CTRL: begin
                    // Comparator bit is read only, so it is masked out of the store
                    conv_ctrl_reg <= req.wdata & pump_adc_pkg::CONV_CTRL_WMASK;
                end
                pump_adc_pkg::ADDR_CONV_CLK: begin
                    conv_clk_reg <= req.wdata & pump_adc_pkg::CONV_CLK_WMASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Any write to the pump control register restarts the divided period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pump_restart_reg <= 1'b0;
        end else begin
            pump_restart_reg <= req.wr && (req.addr == pump_adc_pkg::ADDR_PUMP_CTRL);
        end
    end

    // Read data, one cycle after the strobe; unmapped bits read zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                pump_adc_pkg::ADDR_PUMP_CTRL: rdata <= pump_ctrl_reg;
                pump_adc_pkg::ADDR_CONV_CTRL: begin
                    rdata <= conv_ctrl_reg | 8'({cmp_sync_reg, 3'b000});
                end
                pump_adc_pkg::ADDR_CONV_CLK: rdata <= conv_clk_reg;
                pump_adc_pkg::ADDR_CONV_STAT: rdata <= {7'h00, irq_flag_reg};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Comparator synchroniser; first stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmp_meta_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
            cmp_prev_reg <= 1'b0;
        end else begin
            cmp_meta_reg <= comparator_out;
            cmp_sync_reg <= cmp_meta_reg;
            cmp_prev_reg <= cmp_sync_reg;
        end
    end

    always_comb begin
        case (trig)
            pump_adc_pkg::TRIG_NONE: edge_hit = 1'b0;
            pump_adc_pkg::TRIG_RISE: edge_hit = cmp_sync_reg && !cmp_prev_reg;
            pump_adc_pkg::TRIG_FALL: edge_hit = !cmp_sync_reg && cmp_prev_reg;
            pump_adc_pkg::TRIG_BOTH: edge_hit = cmp_sync_reg != cmp_prev_reg;
            default: edge_hit = 1'b0;
        endcase
    end

    // Sticky request flag: writing 1 to the status bit clears it, a new edge wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_flag_reg <= 1'b0;
        end else if (edge_hit) begin
            irq_flag_reg <= 1'b1;
        end else if (req.wr && req.addr == pump_adc_pkg::ADDR_CONV_STAT
                && req.wdata[pump_adc_pkg::IRQ_FLAG_BIT]) begin
            irq_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            conv_irq <= 1'b0;
        end else begin
            conv_irq <= irq_flag_reg;
        end
    end

    clock_divider #(.PRE_W(4), .DIV_W(5)) pump_div (
        .clk(clk),
        .nrst(nrst),
        .run(pump_run),
        .restart(pump_restart_reg),
        .pre_last(pump_adc_pkg::PUMP_PRE_LAST),
        .div_last(pump_ctrl_reg[pump_adc_pkg::PUMP_DIV_MSB:pump_adc_pkg::PUMP_DIV_LSB]),
        .clk_out(pump_clk_raw)
    );

    clock_divider #(.PRE_W(5), .DIV_W(7)) chop_div (
        .clk(clk),
        .nrst(nrst),
        .run(conv_on && conv_ctrl_reg[pump_adc_pkg::CHOP_EN_BIT]),
        .restart(1'b0),
        .pre_last(pump_adc_pkg::CHOP_PRE_LAST),
        .div_last(chop_last),
        .clk_out(chop_clk_raw)
    );

    // Toggle outputs: the half-ratio prescale makes the full period equal the ratio
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pump_clk <= 1'b0;
            chopper_clk <= 1'b0;
        end else begin
            pump_clk <= pump_clk_raw;
            chopper_clk <= chop_clk_raw;
        end
    end

    always_comb begin
        analog_next.regulator_on = module_en;
        analog_next.pump_run = pump_run;
        analog_next.bandgap_on = module_en;
        analog_next.bandgap_filter = pump_ctrl_reg[pump_adc_pkg::QUICK_START_BIT];
        analog_next.analog_enable = module_en;
        analog_next.conv_power = conv_on;
        analog_next.charge_sw = conv_on && slope == pump_adc_pkg::SLOPE_CHARGE;
        analog_next.discharge_sw = conv_on && slope == pump_adc_pkg::SLOPE_DISCHARGE;
        analog_next.gain_input_select =
            pump_adc_pkg::insel_t'(conv_clk_reg[pump_adc_pkg::INSEL_LSB +: 2]);
        analog_next.gain_select = conv_clk_reg[pump_adc_pkg::GAIN_SEL_BIT];
        analog_next.reference_select = conv_clk_reg[pump_adc_pkg::REF_SEL_BIT];
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            analog_ctrl <= '0;
        end else begin
            analog_ctrl <= analog_next;
        end
    end
endmodule // pump_adc_ctrl
`default_nettype wire

// ### core/pump_adc_pkg.sv
// Package: register map, field layout, reset values and timing for pump regulator and slope converter control
package pump_adc_pkg;
    localparam logic [1:0] ADDR_PUMP_CTRL = 2'h0;
    localparam logic [1:0] ADDR_CONV_CTRL = 2'h1;
    localparam logic [1:0] ADDR_CONV_CLK = 2'h2;
    localparam logic [1:0] ADDR_CONV_STAT = 2'h3;

    localparam int PUMP_DIV_LSB = 3;
    localparam int PUMP_DIV_MSB = 7;
    localparam int QUICK_START_BIT = 2;
    localparam int PUMP_EN_BIT = 1;
    localparam int MODULE_EN_BIT = 0;

    localparam int CHOP_EN_BIT = 6;
    localparam int TRIG_LSB = 4;
    localparam int CMP_OUT_BIT = 3;
    localparam int SLOPE_LSB = 1;
    localparam int CONV_PWR_BIT = 0;

    localparam int GAIN_SEL_BIT = 7;
    localparam int INSEL_LSB = 5;
    localparam int REF_SEL_BIT = 4;
    localparam int CHOP_DIV_LSB = 0;

    localparam int IRQ_FLAG_BIT = 0;

    localparam logic [7:0] PUMP_CTRL_RESET = 8'h00;
    localparam logic [7:0] CONV_CTRL_RESET = 8'h00;
    localparam logic [7:0] CONV_CLK_RESET = 8'h07;

    localparam logic [7:0] CONV_CTRL_WMASK = 8'h77;
    localparam logic [7:0] CONV_CLK_WMASK = 8'hF7;

    localparam int PUMP_PRESCALE = 16;
    localparam int CHOP_PRESCALE = 32;
    // Dividers toggle their output, so each prescaler wraps at half the ratio
    localparam logic [3:0] PUMP_PRE_LAST = 4'(PUMP_PRESCALE / 2 - 1);
    localparam logic [4:0] CHOP_PRE_LAST = 5'(CHOP_PRESCALE / 2 - 1);

    typedef enum logic [1:0] {
        TRIG_NONE = 2'b00,
        TRIG_RISE = 2'b01,
        TRIG_FALL = 2'b10,
        TRIG_BOTH = 2'b11
    } trig_mode_t;

    typedef enum logic [1:0] {
        SLOPE_RSVD0 = 2'b00,
        SLOPE_CHARGE = 2'b01,
        SLOPE_DISCHARGE = 2'b10,
        SLOPE_RSVD3 = 2'b11
    } slope_t;

    typedef enum logic [1:0] {
        IN_SENSOR = 2'b00,
        IN_THERMAL_BATTERY = 2'b01,
        IN_CHOPPER = 2'b10,
        IN_RSVD = 2'b11
    } insel_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic regulator_on;
        logic pump_run;
        logic bandgap_on;
        logic bandgap_filter;
        logic analog_enable;
        logic conv_power;
        logic charge_sw;
        logic discharge_sw;
        insel_t gain_input_select;
        logic gain_select;
        logic reference_select;
    } analog_ctrl_t;
endpackage

// ### core/clock_divider.sv
// Clock divider: fixed prescale then a selectable terminal count, with a restart input
`timescale 1ns/10ps
`default_nettype none
module clock_divider #(
    parameter int PRE_W = 4,
    parameter int DIV_W = 5
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic restart,
    input wire logic [PRE_W-1:0] pre_last,
    input wire logic [DIV_W-1:0] div_last,
    output logic clk_out
);
    logic [PRE_W-1:0] pre_reg;
    logic [DIV_W-1:0] div_reg;
    logic pre_wrap;

    assign pre_wrap = (pre_reg == pre_last);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_reg <= '0;
        end else if (!run || restart) begin
            pre_reg <= '0;
        end else if (pre_wrap) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
        end
    end

    // Output toggles once per full divided period, so it is a 50% square wave of twice that period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_reg <= '0;
            clk_out <= 1'b0;
        end else if (!run || restart) begin
            div_reg <= '0;
            clk_out <= 1'b0;
        end else if (pre_wrap) begin
            if (div_reg >= div_last) begin
                div_reg <= '0;
                clk_out <= ~clk_out;
            end else begin
                div_reg <= div_reg + 1'b1;
            end
        end
    end
endmodule // clock_divider
`default_nettype wire

// ### verif/pump_adc_ctrl_asserts.sv
// Checker: port-level properties of the pump and converter control block
`timescale 1ns/10ps
`default_nettype none
module pump_adc_ctrl_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic comparator_out,
    input wire logic pump_clk,
    input wire logic chopper_clk,
    input wire pump_adc_pkg::analog_ctrl_t analog_ctrl,
    input wire logic conv_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_pump_needs_reg: assert property (analog_ctrl.pump_run |-> analog_ctrl.regulator_on)
        else $error("pump runs without regulator");
    chk_off_all_dark: assert property (!analog_ctrl.regulator_on |->
        !analog_ctrl.analog_enable && !analog_ctrl.conv_power)
        else $error("analog alive with module off");
    chk_bandgap_follows: assert property (analog_ctrl.bandgap_on == analog_ctrl.regulator_on)
        else $error("bandgap differs from regulator");
    chk_pump_write_map: assert property (wr && addr == 2'h0 ##2 1'b1 |->
        analog_ctrl.pump_run == ($past(wdata[1], 2) && $past(wdata[0], 2)))
        else $error("pump run not per write");
    chk_pump_idle_low: assert property (!analog_ctrl.pump_run [*3] |-> !pump_clk)
        else $error("pump clock while stopped");
    chk_chop_idle_low: assert property (!analog_ctrl.conv_power [*3] |-> !chopper_clk)
        else $error("chopper clock while off");
    chk_switch_exclusive: assert property (analog_ctrl.charge_sw |-> !analog_ctrl.discharge_sw)
        else $error("both slope switches on");
    chk_irq_has_edge: assert property ($rose(conv_irq) |->
        $past(comparator_out, 1) != $past(comparator_out, 7))
        else $error("interrupt without comparator edge");
    cover property (analog_ctrl.pump_run);
    cover property (analog_ctrl.discharge_sw);
    cover property ($rose(conv_irq));
endmodule // pump_adc_ctrl_chk
bind pump_adc_ctrl pump_adc_ctrl_chk chk_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .comparator_out(comparator_out), .pump_clk(pump_clk), .chopper_clk(chopper_clk),
    .analog_ctrl(analog_ctrl), .conv_irq(conv_irq));
`default_nettype wire

// ### verif/pump_adc_ctrl_test.sv
// Testbench: self-checking scenarios for the pump and converter control block
`timescale 1ns/10ps
`default_nettype none
module pump_adc_ctrl_test;
    logic clk, nrst, wr, rd, comparator_out, pump_clk, chopper_clk, conv_irq;
    logic [1:0] addr, q;
    logic [7:0] wdata, rdata, v;
    pump_adc_pkg::analog_ctrl_t ac;
    int error_cnt = 0;
    int cmp_count = 0;
    pump_adc_ctrl dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .comparator_out(comparator_out), .pump_clk(pump_clk),
        .chopper_clk(chopper_clk), .analog_ctrl(ac), .conv_irq(conv_irq));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic final_report();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic ck(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic ck1(input logic g, input logic e);
        ck(16'(g), 16'(e));
    endtask
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        ck(16'(rdata), 16'(e));
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Period is taken between two rising edges, so restart jitter is ignored
    task automatic per(input bit s, input int e);
        int n;
        int k;
        logic p;
        logic c;
        n = 0;
        k = 0;
        p = 1'b1;
        while (k < 2 && n < 5000) begin
            @(posedge clk);
            #1;
            c = s ? chopper_clk : pump_clk;
            k = (c === 1'b1 && p === 1'b0) ? k + 1 : k;
            n = (k == 1 && c === 1'b1 && p === 1'b0) ? 0 : n;
            p = c;
            n++;
        end
        if (k < 2) begin
            error_cnt++;
            $display("BAD %0t clock never toggled", $time);
            final_report();
        end
        ck(16'(n - 1), 16'(e));
    endtask
    task automatic t_pump();
        wreg(2'h0, 8'h02);
        settle();
        ck1(ac.pump_run, 1'b0);
        ck1(ac.regulator_on, 1'b0);
        wreg(2'h0, 8'h03);
        settle();
        ck1(ac.pump_run, 1'b1);
        ck1(ac.bandgap_on, 1'b1);
        ck1(ac.bandgap_filter, 1'b0);
        wreg(2'h0, 8'h05);
        settle();
        ck1(ac.pump_run, 1'b0);
        ck1(ac.bandgap_filter, 1'b1);
        for (int d = 0; d < 32; d += 31) begin
            wreg(2'h0, 8'(d * 8 + 3));
            rreg(2'h0, 8'(d * 8 + 3));
            per(1'b0, pump_adc_pkg::PUMP_PRESCALE * (d + 1));
        end
        wreg(2'h0, 8'h5B);
        per(1'b0, pump_adc_pkg::PUMP_PRESCALE * 12);
    endtask
    task automatic t_conv();
        for (int s = 0; s < 4; s++) begin
            wreg(2'h1, 8'(s * 2 + 1));
            settle();
            ck1(ac.conv_power, 1'b1);
            ck1(ac.charge_sw, 1'(s == 1));
            ck1(ac.discharge_sw, 1'(s == 2));
        end
        wreg(2'h1, 8'h8B);
        rreg(2'h1, 8'h03);
        for (int i = 0; i < 4; i++) begin
            q = 2'(i);
            v = {q[0], q, q[1], 4'hD};
            wreg(2'h2, v);
            settle();
            ck1(ac.gain_select, q[0]);
            ck(16'(ac.gain_input_select), 16'(q));
            ck1(ac.reference_select, q[1]);
            rreg(2'h2, v & pump_adc_pkg::CONV_CLK_WMASK);
        end
        wreg(2'h0, 8'h00);
        settle();
        ck1(ac.conv_power, 1'b0);
        ck1(ac.charge_sw, 1'b0);
        wreg(2'h0, 8'h01);
        wreg(2'h1, 8'h41);
        for (int s = 0; s < 3; s += 2) begin
            wreg(2'h2, 8'(s));
            per(1'b1, pump_adc_pkg::CHOP_PRESCALE * (1 << s));
        end
    endtask
    task automatic t_irq();
        for (int m = 0; m < 4; m++) begin
            q = 2'(m);
            wreg(2'h1, {2'b00, q, 4'h1});
            wreg(2'h3, 8'h01);
            comparator_out <= 1'b1;
            repeat (6) @(posedge clk);
            rreg(2'h3, {7'h00, q[0]});
            rreg(2'h1, {2'b00, q, 4'h9});
            wreg(2'h3, 8'h01);
            comparator_out <= 1'b0;
            repeat (6) @(posedge clk);
            #1;
            ck1(conv_irq, q[1]);
        end
    endtask
    initial begin
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        comparator_out = 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rreg(2'h0, 8'h00);
        rreg(2'h2, pump_adc_pkg::CONV_CLK_RESET);
        ck(16'(ac), 16'h0000);
        t_pump();
        t_conv();
        t_irq();
        final_report();
    end
endmodule // pump_adc_ctrl_test
`default_nettype wire
